// [hdl/sleep_wake_interrupt_control.sv]
// sleep entry, wake sequencing and vector dispatch with an axi4-lite register port
//
// Functional notes
// - sleep is entered only if the arm bit is one when the core issues the sleep instruction.
// - the three-bit mode field picks idle, noise reduction, power-down, power-save or standby.
// - an enabled request during sleep wakes the block, adds four halt cycles after start-up, then dispatches.
// - waking never clears or rewrites register file or static memory contents.
// - a reset during sleep wakes the block and dispatches the reset vector.
// - bits 7..4 of the sleep control register read as zero and ignore writes.
// - a request is taken only when its own enable and the global enable are both one.
// - with boot lock bits programmed, requests are suppressed depending on the program counter.
// - reset and request vectors sit at the lowest program addresses by default.
// - the lowest vector wins; reset first, then external request zero.
// - with the relocate bit set, request vectors are based at the boot section start.
// - with the boot reset fuse programmed, the reset vector is the boot section start.
// - accepting a request clears the global enable.
// - global enable set inside a handler lets enabled requests preempt it.
// - the return-from-handler instruction sets the global enable.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sleep_wake_interrupt_control
  import sleep_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  // axi4-lite write data
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  // axi4-lite write response
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // axi4-lite read address
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  // axi4-lite read data
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // core
  input  wire logic             sleep_instr,
  input  wire logic             return_from_handler_instr,
  input  wire logic [11:0]      core_pc,
  output logic                  core_stall,
  output logic                  vector_valid,
  output logic [11:0]           vector_addr,
  output logic                  vector_is_reset,
  // request sources
  input  wire logic [N_IRQ-1:0] irq_req,
  output logic [N_IRQ-1:0]      irq_ack,
  // fuses and lock bits
  input  wire logic             boot_reset_fuse,
  input  wire logic             boot_lock_app_bit,
  input  wire logic             boot_lock_boot_bit,
  // power control
  output logic                  sleep_active,
  output logic [2:0]            sleep_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ctl_state_e       st;
    logic [7:0]       cnt;
    logic             arm;
    logic [2:0]       mode;
    logic             relocate;
    logic             gie;
    logic [N_IRQ-1:0] ien;
    logic             sleeping;
    logic [2:0]       sleep_mode;
    logic             stall;
    logic             vec_valid;
    logic [11:0]      vec_addr;
    logic             vec_reset;
    logic [N_IRQ-1:0] ack;
    logic             awready;
    logic             wready;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       aw_addr;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;

  logic [N_IRQ-1:0] taken;
  logic             suppress;
  logic             sel_any;
  logic [2:0]       sel_idx;
  logic [11:0]      sel_addr;
  logic [11:0]      irq_base;
  logic             mode_legal;
  logic             slow_start;

  ////////////////////////////////////////////////////////////////////////////
  // request qualification

  always_comb begin
    suppress = (boot_lock_app_bit && !s_q.relocate && core_pc >= BOOT_START) ||
               (boot_lock_boot_bit && s_q.relocate && core_pc < BOOT_START);
    taken    = (s_q.gie && !suppress) ? (irq_req & s_q.ien) : '0;
    irq_base = s_q.relocate ? BOOT_START : 12'h000;
    mode_legal = (s_q.mode == MODE_IDLE) || (s_q.mode == MODE_NOISE_RED) ||
                 (s_q.mode == MODE_POWER_DN) || (s_q.mode == MODE_POWER_SV) ||
                 (s_q.mode == MODE_STANDBY);
    slow_start = (s_q.sleep_mode != MODE_IDLE) && (s_q.sleep_mode != MODE_NOISE_RED);
  end

  vector_select u_vector_select (
    .pending (taken),
    .base    (irq_base),
    .any     (sel_any),
    .idx     (sel_idx),
    .addr    (sel_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d           = s_q;
    s_d.vec_valid = 1'b0;
    s_d.vec_reset = 1'b0;
    s_d.ack       = '0;

    // bus write
    if (awvalid && s_q.awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got   = 1'b1;
      s_d.w_byte  = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      case (s_q.aw_addr)
        ADDR_SLEEP_CONTROL: begin
          if (s_q.w_lane0) begin
            s_d.arm  = s_q.w_byte[ARM_BIT];
            s_d.mode = s_q.w_byte[MODE_LSB +: 3];
          end
        end
        ADDR_CORE_CONTROL: begin
          if (s_q.w_lane0) begin
            s_d.relocate = s_q.w_byte[RELOCATE_BIT];
          end
        end
        ADDR_STATUS: begin
          if (s_q.w_lane0) begin
            s_d.gie = s_q.w_byte[GIE_BIT];
          end
        end
        ADDR_IRQ_ENABLE: begin
          if (s_q.w_lane0) begin
            s_d.ien = s_q.w_byte;
          end
        end
        ADDR_IRQ_PENDING, ADDR_BLOCK_STATE: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // bus read
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      case (araddr)
        ADDR_SLEEP_CONTROL: begin
          s_d.rdata[3:0] = {s_q.mode, s_q.arm};
        end
        ADDR_CORE_CONTROL: begin
          s_d.rdata[RELOCATE_BIT] = s_q.relocate;
        end
        ADDR_STATUS: begin
          s_d.rdata[GIE_BIT] = s_q.gie;
        end
        ADDR_IRQ_ENABLE: begin
          s_d.rdata[7:0] = s_q.ien;
        end
        ADDR_IRQ_PENDING: begin
          s_d.rdata[7:0] = irq_req;
        end
        ADDR_BLOCK_STATE: begin
          s_d.rdata[2:0]                = s_q.st;
          s_d.rdata[STALL_BIT]          = s_q.stall;
          s_d.rdata[MODE_OUT_LSB +: 3]  = s_q.sleep_mode;
          s_d.rdata[SLEEP_BIT]          = s_q.sleeping;
        end
        default: begin
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // return from handler sets the global enable
    if (return_from_handler_instr) begin
      s_d.gie = 1'b1;
    end

    // sequencer
    case (s_q.st)
      ST_RESET_VEC: begin
        s_d.vec_valid = 1'b1;
        s_d.vec_reset = 1'b1;
        s_d.vec_addr  = boot_reset_fuse ? BOOT_START : vec_addr(12'h000, 4'h0);
        s_d.stall     = 1'b0;
        s_d.st        = ST_RUN;
      end
      ST_RUN: begin
        if (sel_any) begin
          s_d.vec_valid     = 1'b1;
          s_d.vec_addr      = sel_addr;
          s_d.ack[sel_idx]  = 1'b1;
          s_d.gie           = 1'b0;
        end else if (sleep_instr && s_q.arm && mode_legal) begin
          s_d.st         = ST_SLEEP;
          s_d.sleeping   = 1'b1;
          s_d.sleep_mode = s_q.mode;
          s_d.stall      = 1'b1;
        end
        // unarmed sleep falls through as a no-operation
      end
      ST_SLEEP: begin
        if (sel_any) begin
          s_d.sleeping = 1'b0;
          s_d.cnt      = slow_start ? 8'(STARTUP_CYCLES - 1) : 8'(HALT_CYCLES - 1);
          s_d.st       = slow_start ? ST_STARTUP : ST_HALT;
        end
      end
      ST_STARTUP: begin
        if (s_q.cnt == 8'h00) begin
          s_d.cnt = 8'(HALT_CYCLES - 1);
          s_d.st  = ST_HALT;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ST_HALT: begin
        if (s_q.cnt == 8'h00) begin
          s_d.stall = 1'b0;
          s_d.st    = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      default: begin
        s_d.st = ST_RESET_VEC;
      end
    endcase

    // ready flags follow the captured state
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.st         <= ST_RESET_VEC;
      s_q.arm        <= SLEEP_CONTROL_RST[ARM_BIT];
      s_q.mode       <= SLEEP_CONTROL_RST[MODE_LSB +: 3];
      s_q.relocate   <= RELOCATE_RST;
      s_q.gie        <= GIE_RST;
      s_q.ien        <= IRQ_ENABLE_RST;
      s_q.stall      <= 1'b1;
      s_q.sleep_mode <= MODE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    awready         = s_q.awready;
    wready          = s_q.wready;
    bvalid          = s_q.bvalid;
    bresp           = s_q.bresp;
    arready         = s_q.arready;
    rvalid          = s_q.rvalid;
    rdata           = s_q.rdata;
    rresp           = s_q.rresp;
    core_stall      = s_q.stall;
    vector_valid    = s_q.vec_valid;
    vector_addr     = s_q.vec_addr;
    vector_is_reset = s_q.vec_reset;
    irq_ack         = s_q.ack;
    sleep_active    = s_q.sleeping;
    sleep_mode      = s_q.sleep_mode;
  end

endmodule // sleep_wake_interrupt_control

// [hdl/sleep_pkg.sv]
// constants, types and vector arithmetic for the sleep and interrupt controller
package sleep_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CORE_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS        = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_PENDING   = 8'h10;
  localparam logic [7:0] ADDR_BLOCK_STATE   = 8'h14;

  // field positions
  localparam int ARM_BIT      = 0;
  localparam int MODE_LSB     = 1;
  localparam int RELOCATE_BIT = 1;
  localparam int GIE_BIT      = 7;
  localparam int STALL_BIT    = 3;
  localparam int MODE_OUT_LSB = 4;
  localparam int SLEEP_BIT    = 7;

  // reset values
  localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
  localparam logic       RELOCATE_RST      = 1'b0;
  localparam logic       GIE_RST           = 1'b0;
  localparam logic [7:0] IRQ_ENABLE_RST    = 8'h00;

  // sleep mode encodings
  localparam logic [2:0] MODE_IDLE      = 3'h0;
  localparam logic [2:0] MODE_NOISE_RED = 3'h1;
  localparam logic [2:0] MODE_POWER_DN  = 3'h2;
  localparam logic [2:0] MODE_POWER_SV  = 3'h3;
  localparam logic [2:0] MODE_STANDBY   = 3'h6;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // program memory layout
  localparam int          N_IRQ      = 8;
  localparam logic [11:0] BOOT_START = 12'hc00;
  localparam logic [11:0] VEC_STEP   = 12'h001;

  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int STARTUP_NS     = 1000;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_CYCLES    = 4;

  typedef enum logic [2:0] {
    ST_RESET_VEC = 3'b000,
    ST_RUN       = 3'b001,
    ST_SLEEP     = 3'b010,
    ST_STARTUP   = 3'b011,
    ST_HALT      = 3'b100
  } ctl_state_e;

  // vector address: slot 0 is reset, slot n+1 is request n
  function automatic logic [11:0] vec_addr(input logic [11:0] base, input logic [3:0] slot);
    vec_addr = base + 12'(slot) * VEC_STEP;
  endfunction

endpackage

// [hdl/vector_select.sv]
// priority pick of the lowest-numbered pending request and its vector
`timescale 1ns/10ps
module vector_select
  import sleep_pkg::*;
(
  // requests
  input  wire logic [N_IRQ-1:0] pending,
  input  wire logic [11:0]      base,
  // choice
  output logic                  any,
  output logic [2:0]            idx,
  output logic [11:0]           addr
);

  always_comb begin
    any  = 1'b0;
    idx  = 3'h0;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
    addr = vec_addr(base, {1'b0, idx} + 4'h1);
  end

endmodule // vector_select

// [test/sleep_props.sv]
// assertion checker for the sleep and interrupt controller ports
`timescale 1ns/10ps
module sleep_props
  import sleep_pkg::*;
(
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // core side
  input wire logic             sleep_instr,
  input wire logic             core_stall,
  input wire logic             vector_valid,
  input wire logic [11:0]      vector_addr,
  input wire logic             vector_is_reset,
  // requests and fuse
  input wire logic [N_IRQ-1:0] irq_req,
  input wire logic [N_IRQ-1:0] irq_ack,
  input wire logic             boot_reset_fuse,
  // power
  input wire logic             sleep_active,
  input wire logic [2:0]       sleep_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_ENTRY: assert property ($rose(sleep_active) |-> $past(sleep_instr) && core_stall
    && !(sleep_mode inside {3'h4, 3'h5, 3'h7})) else $error("sleep entered without cause");
  AST_QUIET: assert property (sleep_active |-> core_stall && !vector_valid)
    else $error("dispatch or run during sleep");
  AST_WAKE_FAST: assert property ($fell(sleep_active) && sleep_mode inside {3'h0, 3'h1}
    |-> core_stall [*4] ##1 !core_stall) else $error("idle wake halt length wrong");
  AST_WAKE_SLOW: assert property ($fell(sleep_active) && !(sleep_mode inside {3'h0, 3'h1})
    |-> ##23 core_stall ##1 !core_stall) else $error("startup wake length wrong");
  AST_ACK_REQ: assert property (|irq_ack |-> (irq_ack & ~$past(irq_req)) == '0)
    else $error("ack without request");
  AST_VEC: assert property (vector_valid && !vector_is_reset |-> vector_addr[9:4] == 6'h00
    && irq_ack == (8'h01 << (vector_addr[7:0] - 8'h01))) else $error("vector and ack disagree");
  AST_GIE: assert property (vector_valid && !vector_is_reset |=> !vector_valid)
    else $error("dispatch right after dispatch");
  AST_RST: assert property ($rose(aresetn) |-> ##[1:2] (vector_valid && vector_is_reset
    && vector_addr == (boot_reset_fuse ? BOOT_START : 12'h000))) else $error("reset vector wrong");
endmodule // sleep_props

// [test/core_model.sv]
// core and request source model
`timescale 1ns/10ps
module core_model
  import sleep_pkg::*;
(
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // bench commands
  input wire logic [N_IRQ-1:0] raise,
  input wire logic             do_sleep,
  input wire logic             do_return,
  // controller side
  input wire logic [N_IRQ-1:0] irq_ack,
  output logic [N_IRQ-1:0]     irq_req,
  output logic                 sleep_instr,
  output logic                 return_from_handler_instr
);
  // requests held until acknowledged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req                   <= '0;
      sleep_instr               <= 1'b0;
      return_from_handler_instr <= 1'b0;
    end else begin
      irq_req                   <= (irq_req & ~irq_ack) | raise;
      sleep_instr               <= do_sleep;
      return_from_handler_instr <= do_return;
    end
  end
endmodule // core_model

// [test/sleep_wake_interrupt_control_tb.sv]
// self-checking bench for the sleep and interrupt controller
`timescale 1ns/10ps
module sleep_wake_interrupt_control_tb;
  import sleep_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, raise = 0, irq_req, irq_ack;
  logic [31:0] wdata = 0, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic awready, wready, bvalid, arready, rvalid, sleep_instr, rfh_instr, core_stall;
  logic vector_valid, vector_is_reset, sleep_active, vrst, fuse = 0, lock_boot = 0;
  logic do_sleep = 0, do_return = 0;
  logic [11:0] core_pc = 0, vector_addr, vlast;
  logic [2:0] sleep_mode;
  logic [2:0] modes [5] = '{MODE_IDLE, MODE_NOISE_RED, MODE_POWER_DN, MODE_POWER_SV, MODE_STANDBY};
  int failures = 0, tests_run = 0, vcnt = 0, cyc = 0, n0 = 0;
  always #25 aclk = ~aclk;
  sleep_wake_interrupt_control DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sleep_instr(sleep_instr),
    .return_from_handler_instr(rfh_instr), .core_pc(core_pc), .core_stall(core_stall),
    .vector_valid(vector_valid), .vector_addr(vector_addr), .vector_is_reset(vector_is_reset),
    .irq_req(irq_req), .irq_ack(irq_ack), .boot_reset_fuse(fuse), .boot_lock_app_bit(1'b0),
    .boot_lock_boot_bit(lock_boot), .sleep_active(sleep_active), .sleep_mode(sleep_mode));
  core_model u_core (.aclk(aclk), .aresetn(aresetn), .raise(raise), .do_sleep(do_sleep),
    .do_return(do_return), .irq_ack(irq_ack), .irq_req(irq_req), .sleep_instr(sleep_instr),
    .return_from_handler_instr(rfh_instr));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (vector_valid) begin
      vcnt  <= vcnt + 1;
      vlast <= vector_addr;
      vrst  <= vector_is_reset;
    end
    if (cyc == 20000) begin
      failures = failures + 1;
      stop_test();
    end
  end
  task stop_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd_d = rdata; rd_r = rresp; rready <= 0;
  endtask
  task cmd(input logic s);
    @(posedge aclk);
    do_sleep <= s;
    do_return <= ~s;
    @(posedge aclk);
    do_sleep <= 0;
    do_return <= 0;
  endtask
  task req(input logic [7:0] m);
    @(posedge aclk); raise <= m;
    @(posedge aclk); raise <= '0;
  endtask
  task wait_v();
    for (int i = 0; i < 80 && vcnt == n0; i++) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    wait_v();
    chk(vlast, 12'h000);
    chk(vrst, 1);
    rd(ADDR_SLEEP_CONTROL);
    chk(rd_d, SLEEP_CONTROL_RST);
    chk(rd_r, RESP_OKAY);
    wr(ADDR_SLEEP_CONTROL, 32'hff);
    chk(wr_r, RESP_OKAY);
    rd(ADDR_SLEEP_CONTROL);
    chk(rd_d, 32'h0f);
    wr(ADDR_SLEEP_CONTROL, 32'h09); cmd(1); repeat (3) @(posedge aclk);
    chk(sleep_active, 0);
    wr(ADDR_SLEEP_CONTROL, 32'h04); cmd(1); repeat (3) @(posedge aclk);
    chk(sleep_active, 0);
    rd(8'h40); chk(rd_r, RESP_SLVERR);
    wr(8'h40, 32'h01);
    chk(wr_r, RESP_SLVERR);
    wr(ADDR_IRQ_ENABLE, 32'h01); wr(ADDR_STATUS, 32'h80);
    foreach (modes[i]) begin
      wr(ADDR_SLEEP_CONTROL, {28'h0, modes[i], 1'b1});
      cmd(1); repeat (3) @(posedge aclk);
      chk(sleep_active, 1);
      chk(sleep_mode, modes[i]);
      chk(core_stall, 1);
      n0 = vcnt; req(8'h01); wait_v();
      chk(vlast, 12'h001);
      chk(vrst, 0);
      chk(core_stall, 0);
      wr(ADDR_SLEEP_CONTROL, 32'h00);
      cmd(0);
    end
    rd(ADDR_IRQ_ENABLE);
    chk(rd_d, 32'h01);
    rd(ADDR_STATUS); chk(rd_d, 32'h80);
    wr(ADDR_STATUS, 32'h00); wr(ADDR_IRQ_ENABLE, 32'hff);
    n0 = vcnt; req(8'h2a); wait_v(); chk(vcnt, n0);
    rd(ADDR_IRQ_PENDING);
    chk(rd_d, 32'h2a);
    wr(ADDR_STATUS, 32'h80); wait_v(); chk(vlast, 12'h002);
    rd(ADDR_STATUS); chk(rd_d, 32'h00);
    n0 = vcnt; wr(ADDR_STATUS, 32'h80); wait_v(); chk(vlast, 12'h004);
    n0 = vcnt; cmd(0); wait_v(); chk(vlast, 12'h006);
    cmd(0); wr(ADDR_CORE_CONTROL, 32'h02); lock_boot <= 1;
    n0 = vcnt; req(8'h01); wait_v(); chk(vcnt, n0);
    core_pc <= BOOT_START; wait_v(); chk(vlast, 12'hc01);
    fuse <= 1; wr(ADDR_SLEEP_CONTROL, 32'h05); cmd(1); repeat (3) @(posedge aclk);
    chk(sleep_active, 1);
    rd(ADDR_BLOCK_STATE);
    chk(rd_d, 32'haa);
    n0 = vcnt; aresetn <= 0; repeat (3) @(posedge aclk); aresetn <= 1; wait_v();
    chk(vlast, 12'hc00);
    chk(vrst, 1);
    stop_test();
  end
endmodule // sleep_wake_interrupt_control_tb
bind sleep_wake_interrupt_control sleep_props u_props (.aclk(aclk), .aresetn(aresetn),
  .sleep_instr(sleep_instr), .core_stall(core_stall), .vector_valid(vector_valid),
  .vector_addr(vector_addr), .vector_is_reset(vector_is_reset), .irq_req(irq_req),
  .irq_ack(irq_ack), .boot_reset_fuse(boot_reset_fuse), .sleep_active(sleep_active),
  .sleep_mode(sleep_mode));
